// ---- hw/hbridge_spi_control_logic.sv ----
// Operation
// [R1] enable low: all switches off, sleep
// [R2] enable high: normal operation
// [R3] tristate request high: switches off, standby
// [R4] tristate request low: outputs follow direction
// [R5] never both switches on in one leg
// [R6] direction inputs pick the pwm low side
// [R7] direction change sequenced with dead time
// [R8] slew setting comes from serial config
// [R9] serial slave only, daisy chainable
// [R10] sample falling, update rising serial clock
// [R11] words travel msb first
// [R12] after 16 bits, echo input to output
// [R13] serial output tristated unless selected
// [R14] select rise commits word to register
// [R15] select fall loads previously addressed register
// [R16] fault flag low on unmasked fault
// [R17] fault flag open drain, pulls low only
// [R18] direction mapping as parameter table
// [R19] count edges, sixteen bits per word
module hbridge_spi_control_logic
    import hbridge_pkg::*;
#(
    // each entry {leg_a, leg_b}, index {dir_a, dir_b}
    parameter logic [3:0][3:0] DIR_TABLE = {
        {LEG_HIGH, LEG_HIGH},
        {LEG_HIGH, LEG_PWM},
        {LEG_PWM, LEG_HIGH},
        {LEG_LOW, LEG_LOW}
    }
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wake_enable_in_i,
    input wire logic tristate_request_in_i,
    input wire logic direction_ctrl_a_i,
    input wire logic direction_ctrl_b_i,
    input wire logic pwm_i,
    input wire logic [hbridge_pkg::FAULT_W-1:0] fault_status_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_n_o,
    output logic bridge_leg_a_high_o,
    output logic bridge_leg_a_low_o,
    output logic bridge_leg_b_high_o,
    output logic bridge_leg_b_low_o,
    output logic [hbridge_pkg::SLEW_W-1:0] slew_sel_o,
    output logic [1:0] mode_o,
    output logic fault_flag_n_o,
    output logic fault_flag_n_oe_n_o
);
    // ==========================================
    // state
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sclk_s;
        logic [1:0] mosi_s;
        logic [1:0] ena_s;
        logic [1:0] dis_s;
        logic [1:0] dira_s;
        logic [1:0] dirb_s;
        logic [1:0] pwm_s;
        logic cs_prev;
        logic sclk_prev;
        logic [WORD_BITS-1:0] shreg;
        logic [CNT_W-1:0] cnt;
        logic [ADDR_W-1:0] prev_addr;
        logic rx_full;
        logic miso;
        logic miso_oe_n;
        logic [FAULT_W-1:0] mask;
        logic [SLEW_W-1:0] slew;
        logic [3:0] cur_sel;
        logic [DEAD_W-1:0] dead;
        logic [3:0] legs;
        bridge_mode_type mode;
        logic flag_oe_n;
    } ctrl_state_type;

    ctrl_state_type s_q;
    ctrl_state_type s_d;

    logic mem_wr;
    logic [ADDR_W-1:0] mem_waddr;
    logic [WORD_BITS-1:0] mem_wdata;
    logic [WORD_BITS-1:0] mem_rdata;
    logic [WORD_BITS-1:0] fault_word;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic [3:0] want;
    logic [1:0] dir_idx;

    // config lives in memory; readback through one registered port
    hbridge_reg_mem u_mem (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(mem_wr),
        .wr_addr_i(mem_waddr),
        .wr_data_i(mem_wdata),
        .rd_addr_i(s_q.prev_addr),
        .rd_data_o(mem_rdata)
    );

    // ==========================================
    // leg helper: one switch per leg at most
    function automatic logic [1:0] leg_drive(input logic [1:0] code, input logic pwm);
        logic [1:0] r;
        r = 2'h0;
        case (code)
            LEG_HIGH: r = 2'h2;
            LEG_LOW: r = 2'h1;
            LEG_PWM: r = {1'b0, pwm}; // R6
            default: r = 2'h0;
        endcase
        return r;
    endfunction : leg_drive

    always_comb begin
        s_d = s_q;
        mem_wr = 1'b0;
        mem_waddr = s_q.shreg[ADDR_LSB +: ADDR_W];
        mem_wdata = s_q.shreg;
        // two-flop synchronisers; only the second stage is read
        s_d.cs_s = {s_q.cs_s[0], spi_cs_n_i};
        s_d.sclk_s = {s_q.sclk_s[0], spi_sclk_i};
        s_d.mosi_s = {s_q.mosi_s[0], spi_mosi_i};
        s_d.ena_s = {s_q.ena_s[0], wake_enable_in_i};
        s_d.dis_s = {s_q.dis_s[0], tristate_request_in_i};
        s_d.dira_s = {s_q.dira_s[0], direction_ctrl_a_i};
        s_d.dirb_s = {s_q.dirb_s[0], direction_ctrl_b_i};
        s_d.pwm_s = {s_q.pwm_s[0], pwm_i};
        s_d.cs_prev = s_q.cs_s[1];
        s_d.sclk_prev = s_q.sclk_s[1];
        cs_rise = s_q.cs_s[1] && !s_q.cs_prev;
        cs_fall = !s_q.cs_s[1] && s_q.cs_prev;
        selected = !s_q.cs_s[1];
        sclk_rise = s_q.sclk_s[1] && !s_q.sclk_prev;
        sclk_fall = !s_q.sclk_s[1] && s_q.sclk_prev;
        fault_word = WORD_ZERO;
        fault_word[FAULT_W-1:0] = fault_status_i;

        // ==========================================
        // serial slave
        if (cs_fall) begin
            // fault flags if the fault register was addressed last, else the previously addressed register
            s_d.shreg = (s_q.prev_addr == ADDR_FAULT) ? fault_word : mem_rdata; // R15
            s_d.cnt = '0;
            s_d.rx_full = 1'b0;
        end else if (selected && sclk_fall) begin
            s_d.shreg = {s_q.shreg[WORD_BITS-2:0], s_q.mosi_s[1]}; // R10 R11
            s_d.cnt = s_q.cnt + 1'b1; // R19
            if (s_q.cnt == CNT_LAST) begin
                s_d.rx_full = 1'b1;
            end
        end
        if (selected && sclk_rise) begin
            // later words: the shreg msb is the mosi bit from 16 edges back
            s_d.miso = s_q.shreg[WORD_BITS-1]; // R10 R12 R9
        end else if (cs_fall) begin
            s_d.miso = (s_q.prev_addr == ADDR_FAULT) ? fault_word[WORD_BITS-1] : mem_rdata[WORD_BITS-1];
        end
        s_d.miso_oe_n = !selected; // R13
        if (cs_rise && s_q.rx_full) begin
            // last 16 bits in the chain belong to this device
            mem_wr = (s_q.shreg[ADDR_LSB +: ADDR_W] != ADDR_FAULT); // R14
            s_d.prev_addr = s_q.shreg[ADDR_LSB +: ADDR_W];
            if (s_q.shreg[ADDR_LSB +: ADDR_W] == ADDR_MASK) begin
                s_d.mask = s_q.shreg[FAULT_W-1:0];
            end
            if (s_q.shreg[ADDR_LSB +: ADDR_W] == ADDR_CONFIG) begin
                s_d.slew = s_q.shreg[SLEW_LSB +: SLEW_W]; // R8
            end
        end

        // ==========================================
        // mode
        if (!s_q.ena_s[1]) begin
            s_d.mode = MODE_SLEEP; // R1
        end else if (s_q.dis_s[1]) begin
            s_d.mode = MODE_STANDBY; // R3
        end else begin
            s_d.mode = MODE_ACTIVE; // R2 R4
        end

        // ==========================================
        // bridge legs
        dir_idx = {s_q.dira_s[1], s_q.dirb_s[1]};
        s_d.cur_sel = DIR_TABLE[dir_idx]; // R18
        want = {leg_drive(s_q.cur_sel[3:2], s_q.pwm_s[1]), leg_drive(s_q.cur_sel[1:0], s_q.pwm_s[1])};
        if (s_q.mode != MODE_ACTIVE) begin
            s_d.legs = 4'h0; // R1 R3
            s_d.dead = DEAD_ZERO;
        end else if (s_d.cur_sel != s_q.cur_sel) begin
            // all off for a dead time before the new direction
            s_d.legs = 4'h0; // R7
            s_d.dead = DEAD_LOAD;
        end else if (s_q.dead != DEAD_ZERO) begin
            s_d.legs = 4'h0; // R7
            s_d.dead = s_q.dead - 1'b1;
        end else begin
            s_d.legs = want; // R4 R6
        end
        if (s_d.legs[3] && s_d.legs[2]) begin
            s_d.legs[3:2] = 2'h0; // R5
        end
        if (s_d.legs[1] && s_d.legs[0]) begin
            s_d.legs[1:0] = 2'h0; // R5
        end

        // ==========================================
        // fault flag
        s_d.flag_oe_n = !(|(fault_status_i & s_q.mask)); // R16 R17
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.cs_s <= 2'h3;
            s_q.cs_prev <= 1'b1;
            s_q.miso_oe_n <= 1'b1;
            s_q.flag_oe_n <= 1'b1;
            s_q.mask <= MASK_RESET;
            s_q.slew <= SLEW_RESET;
            s_q.mode <= MODE_SLEEP;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // outputs
    assign spi_miso_o = s_q.miso;
    assign spi_miso_oe_n_o = s_q.miso_oe_n;
    assign bridge_leg_a_high_o = s_q.legs[3];
    assign bridge_leg_a_low_o = s_q.legs[2];
    assign bridge_leg_b_high_o = s_q.legs[1];
    assign bridge_leg_b_low_o = s_q.legs[0];
    assign slew_sel_o = s_q.slew;
    assign mode_o = s_q.mode;
    // data pin only ever low; pull-up sits outside
    assign fault_flag_n_o = 1'b0; // R17
    assign fault_flag_n_oe_n_o = s_q.flag_oe_n;
endmodule : hbridge_spi_control_logic

// ---- common/hbridge_pkg.sv ----
package hbridge_pkg;
    // ==========================================
    // serial word
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 4;
    localparam int ADDR_W = 3;
    localparam int ADDR_LSB = 13;
    localparam int NUM_REGS = 8;
    localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
    // ==========================================
    // register addresses inside the serial word
    localparam logic [ADDR_W-1:0] ADDR_FAULT = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 3'h2;
    // ==========================================
    // config fields
    localparam int SLEW_W = 3;
    localparam int SLEW_LSB = 0;
    localparam logic [SLEW_W-1:0] SLEW_RESET = 3'h0;
    localparam int FAULT_W = 8;
    localparam logic [FAULT_W-1:0] MASK_RESET = 8'hff;
    // ==========================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int DEAD_NS = 500;
    localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int DEAD_W = 4;
    localparam logic [DEAD_W-1:0] DEAD_LOAD = DEAD_W'(DEAD_CYC);
    localparam logic [DEAD_W-1:0] DEAD_ZERO = 4'h0;
    // ==========================================
    // leg drive: index {dir_a, dir_b}; per leg 2'b{high,low}
    localparam logic [1:0] LEG_OFF = 2'h0;
    localparam logic [1:0] LEG_LOW = 2'h1;
    localparam logic [1:0] LEG_HIGH = 2'h2;
    localparam logic [1:0] LEG_PWM = 2'h3;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_ACTIVE
    } bridge_mode_type;
endpackage : hbridge_pkg

// ---- hw/hbridge_reg_mem.sv ----
module hbridge_reg_mem
    import hbridge_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [WORD_BITS-1:0] wr_data_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [WORD_BITS-1:0] rd_data_o
);
    // ==========================================
    // storage, registered read
    typedef struct packed {
        logic [NUM_REGS-1:0][WORD_BITS-1:0] mem;
        logic [WORD_BITS-1:0] rd;
    } mem_state_type;

    mem_state_type s_q;
    mem_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en_i) begin
            s_d.mem[wr_addr_i] = wr_data_i;
        end
        s_d.rd = s_q.mem[rd_addr_i];
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data_o = s_q.rd;
endmodule : hbridge_reg_mem

// ---- dv/hbridge_spi_control_logic_sva.sv ----
module hbridge_spi_control_logic_sva
    import hbridge_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wake_enable_in_i,
    input wire logic tristate_request_in_i,
    input wire logic [hbridge_pkg::FAULT_W-1:0] fault_status_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_oe_n_o,
    input wire logic bridge_leg_a_high_o,
    input wire logic bridge_leg_a_low_o,
    input wire logic bridge_leg_b_high_o,
    input wire logic bridge_leg_b_low_o,
    input wire logic [1:0] mode_o,
    input wire logic fault_flag_n_o,
    input wire logic fault_flag_n_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ==========================================
    // sequences
    logic legs_off;
    assign legs_off = !(bridge_leg_a_high_o | bridge_leg_a_low_o | bridge_leg_b_high_o | bridge_leg_b_low_o);
    sequence s_cs_idle; spi_cs_n_i [*5]; endsequence
    // six cycles: two sync flops, mode register, margin
    sequence s_sleep_req; !wake_enable_in_i [*6]; endsequence
    sequence s_standby_req; (wake_enable_in_i && tristate_request_in_i) [*6]; endsequence
    // ==========================================
    // properties
    property p_leg_a_excl; !(bridge_leg_a_high_o && bridge_leg_a_low_o); endproperty
    property p_leg_b_excl; !(bridge_leg_b_high_o && bridge_leg_b_low_o); endproperty
    // legs trail mode by one edge, so mode must hold twice
    property p_sleep_off; (mode_o == MODE_SLEEP) [*2] |-> legs_off; endproperty
    property p_standby_off; (mode_o == MODE_STANDBY) [*2] |-> legs_off; endproperty
    property p_sleep_mode; s_sleep_req |-> mode_o == MODE_SLEEP; endproperty
    property p_standby_mode; s_standby_req |-> mode_o == MODE_STANDBY; endproperty
    property p_miso_hiz; s_cs_idle |-> spi_miso_oe_n_o; endproperty
    property p_flag_low_only; fault_flag_n_o == 1'b0; endproperty
    property p_flag_quiet; fault_status_i == 8'h00 |=> fault_flag_n_oe_n_o; endproperty
    property p_dead_a; $fell(bridge_leg_a_high_o) |=> !bridge_leg_a_low_o [*5]; endproperty
    a_leg_a_excl: assert property (p_leg_a_excl) else $error("leg a shoot through");
    a_leg_b_excl: assert property (p_leg_b_excl) else $error("leg b shoot through");
    a_sleep_off: assert property (p_sleep_off) else $error("legs on in sleep");
    a_standby_off: assert property (p_standby_off) else $error("legs on in standby");
    a_sleep_mode: assert property (p_sleep_mode) else $error("no sleep on enable low");
    a_standby_mode: assert property (p_standby_mode) else $error("no standby");
    a_miso_hiz: assert property (p_miso_hiz) else $error("miso driven while idle");
    a_flag_low_only: assert property (p_flag_low_only) else $error("flag drives high");
    a_flag_quiet: assert property (p_flag_quiet) else $error("flag without fault");
    a_dead_a: assert property (p_dead_a) else $error("leg a no dead time");
endmodule : hbridge_spi_control_logic_sva

// ---- dv/hbridge_spi_host.sv ----
module hbridge_spi_host (
    output logic spi_cs_n_o,
    output logic spi_sclk_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i,
    input wire logic spi_miso_oe_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_NS = 400;
    initial begin
        spi_cs_n_o = 1'b1;
        spi_sclk_o = 1'b0;
        spi_mosi_o = 1'b0;
    end
    // ==========================================
    // master only: low n bits out, msb first
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        spi_cs_n_o = 1'b0;
        #(2 * HALF_NS);
        for (int i = n - 1; i >= 0; i--) begin
            spi_sclk_o = 1'b1;
            spi_mosi_o = tx[i];
            #(HALF_NS);
            // sample on the falling edge, as the device does
            rx[i] = spi_miso_oe_n_i ? 1'bx : spi_miso_i;
            spi_sclk_o = 1'b0;
            #(HALF_NS);
        end
        #(2 * HALF_NS);
        spi_cs_n_o = 1'b1;
        // released data must not look held
        spi_mosi_o = ~spi_mosi_o;
        #(2 * HALF_NS);
    endtask : xfer
endmodule : hbridge_spi_host

// ---- dv/test_hbridge_spi_control_logic.sv ----
module test_hbridge_spi_control_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import hbridge_pkg::*;
    logic sys_clk_i, rst_n_i, wake_enable_in_i, tristate_request_in_i, direction_ctrl_a_i, direction_ctrl_b_i;
    logic pwm_i, spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_n_o;
    logic bridge_leg_a_high_o, bridge_leg_a_low_o, bridge_leg_b_high_o, bridge_leg_b_low_o;
    logic fault_flag_n_o, fault_flag_n_oe_n_o;
    logic [7:0] fault_status_i;
    logic [2:0] slew_sel_o;
    logic [1:0] mode_o;
    logic [31:0] rx;
    int n_errors = 0;
    int check_count = 0;
    // {wake, tristate, dir_a, dir_b, pwm}, {a_hi, a_lo, b_hi, b_lo}, mode
    logic [10:0] rows [8] = '{11'h416, 11'h4da, 11'h48a, 11'h566, 11'h522, 11'h5aa, 11'h781, 11'h140};
    hbridge_spi_control_logic dut (.sys_clk_i, .rst_n_i, .wake_enable_in_i, .tristate_request_in_i,
        .direction_ctrl_a_i, .direction_ctrl_b_i, .pwm_i, .fault_status_i, .spi_cs_n_i, .spi_sclk_i,
        .spi_mosi_i, .spi_miso_o, .spi_miso_oe_n_o, .bridge_leg_a_high_o, .bridge_leg_a_low_o,
        .bridge_leg_b_high_o, .bridge_leg_b_low_o, .slew_sel_o, .mode_o, .fault_flag_n_o, .fault_flag_n_oe_n_o);
    hbridge_spi_host host (.spi_cs_n_o(spi_cs_n_i), .spi_sclk_o(spi_sclk_i), .spi_mosi_o(spi_mosi_i),
        .spi_miso_i(spi_miso_o), .spi_miso_oe_n_i(spi_miso_oe_n_o));
    // ==========================================
    // checking
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        close_out();
    end
    // ==========================================
    // sequence
    initial begin
        rst_n_i = 1'b0;
        {wake_enable_in_i, tristate_request_in_i, direction_ctrl_a_i, direction_ctrl_b_i, pwm_i} = 5'h00;
        fault_status_i = 8'h00;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        chk(16'({bridge_leg_a_high_o, bridge_leg_a_low_o, bridge_leg_b_high_o, bridge_leg_b_low_o}), 16'h0);
        chk(16'({mode_o, spi_miso_oe_n_o, fault_flag_n_oe_n_o, slew_sel_o}), 16'h18);
        foreach (rows[i]) begin
            @(negedge sys_clk_i);
            {wake_enable_in_i, tristate_request_in_i, direction_ctrl_a_i, direction_ctrl_b_i, pwm_i} = rows[i][10:6];
            // sync, mode, dead time and margin
            repeat (14) @(negedge sys_clk_i);
            chk(16'({bridge_leg_a_high_o, bridge_leg_a_low_o, bridge_leg_b_high_o, bridge_leg_b_low_o}),
                16'(rows[i][5:2]));
            chk(16'(mode_o), 16'(rows[i][1:0]));
        end
        {wake_enable_in_i, tristate_request_in_i} = 2'h2;
        repeat (6) @(negedge sys_clk_i);
        host.xfer({16'h1234, 16'h4005}, 32, rx);
        chk(rx[31:16], 16'h0000);
        chk(rx[15:0], 16'h1234);
        chk(16'(slew_sel_o), 16'h5);
        host.xfer(32'h20f0, 16, rx);
        chk(rx[15:0], 16'h4005);
        host.xfer(32'h0, 16, rx);
        chk(rx[15:0], 16'h20f0);
        // short frame must not reach the config
        // fifteen bits would otherwise land as a config write of slew 2
        fault_status_i = 8'h5a;
        host.xfer(32'h4002, 15, rx);
        chk(rx[15:0], 16'h002d);
        chk(16'(slew_sel_o), 16'h5);
        fault_status_i = 8'h0f;
        repeat (3) @(negedge sys_clk_i);
        chk(16'(fault_flag_n_oe_n_o), 16'h1);
        fault_status_i = 8'h10;
        repeat (3) @(negedge sys_clk_i);
        chk(16'({fault_flag_n_oe_n_o, fault_flag_n_o}), 16'h0);
        fault_status_i = 8'h00;
        rst_n_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk(16'({mode_o, slew_sel_o}), 16'h0);
        rst_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        close_out();
    end
endmodule : test_hbridge_spi_control_logic
bind hbridge_spi_control_logic hbridge_spi_control_logic_sva u_sva (.sys_clk_i, .rst_n_i, .wake_enable_in_i,
    .tristate_request_in_i, .fault_status_i, .spi_cs_n_i, .spi_miso_oe_n_o, .bridge_leg_a_high_o,
    .bridge_leg_a_low_o, .bridge_leg_b_high_o, .bridge_leg_b_low_o, .mode_o, .fault_flag_n_o, .fault_flag_n_oe_n_o);
